// ### inc/mrc_pkg.sv
// Constants and the state encoding shared by the repeater core.
package mrc_pkg;

  // Port count: attachment-unit port 0 plus eight twisted-pair ports.
  localparam int MRC_PORTS = 9;
  // Index of the attachment-unit port.
  localparam logic [3:0] MRC_AUI_PORT = 4'h0;
  // Buffer depth in bits.
  localparam int MRC_FIFO_DEPTH = 32;
  // Regenerated preamble length in bit times.
  localparam int MRC_PREAMBLE_BITS = 64;
  // Jam length in bit times.
  localparam int MRC_JAM_BITS = 96;
  // Core clock period in ns.
  localparam int MRC_CLK_NS = 40;
  // Transmit bit period in ns.
  localparam int MRC_BIT_NS = 320;
  // Core clocks per transmitted bit, rounded down.
  localparam int MRC_BIT_CYC = MRC_BIT_NS / MRC_CLK_NS;
  // Reset value of all filtered port indications.
  localparam logic [8:0] MRC_PORTS_RST = 9'h000;

  // Sequencer states, Gray coded along idle, preamble, data, drain.
  typedef enum logic [2:0] {
    MRC_IDLE  = 3'h0,
    MRC_PRE   = 3'h1,
    MRC_DATA  = 3'h3,
    MRC_DRAIN = 3'h2,
    MRC_JAM   = 3'h6
  } mrc_state_t;

endpackage

// ### core/mrc_core.sv
// Repeater data path: bit FIFO and the arbiting, repeating core.

// Bit buffer between the receive side and the transmit selector.
module mrc_fifo import mrc_pkg::*; #(
  parameter int WIDTH = 1,
  parameter int DEPTH = MRC_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Discards all content while high.
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // Pointers carry one extra bit so full and empty are told apart.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } mrc_fifo_t;

  mrc_fifo_t q_r;
  mrc_fifo_t q_nxt;
  logic full;
  logic empty;

  // Power-of-two depth keeps the pointer wrap free of compares.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("mrc_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
  end

  assign full = (q_r.wp[AW] != q_r.rp[AW]) &&
                (q_r.wp[AW-1:0] == q_r.rp[AW-1:0]);
  assign empty = (q_r.wp == q_r.rp);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = q_r.mem[q_r.rp[AW-1:0]];

  // Next-state logic: writes and reads may happen in the same cycle.
  always_comb begin
    q_nxt = q_r;
    if (flush) begin
      q_nxt.wp = '0;
      q_nxt.rp = '0;
    end else begin
      // A bit offered while full is refused and must be counted upstream.
      if (in_valid && !full) begin
        q_nxt.mem[q_r.wp[AW-1:0]] = in_data;
        q_nxt.wp = q_r.wp + 1'b1;
      end
      if (out_ready && !empty) begin
        q_nxt.rp = q_r.rp + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule

// Repeater core: port arbitration, preamble regeneration, repeat, jam.
module mrc_core import mrc_pkg::*; #(
  parameter int PORTS = MRC_PORTS,
  parameter int FIFO_DEPTH = MRC_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Per-port indications from the line transceivers, asynchronous.
  input wire logic [PORTS-1:0] carrier,
  input wire logic [PORTS-1:0] collision,
  // Per-port decoded receive data and recovered receive clock.
  input wire logic [PORTS-1:0] rx_data,
  input wire logic [PORTS-1:0] rx_clk,
  // Transmit stream to the encoder and per-port transmit enables.
  output logic tx_clk,
  output logic tx_data,
  output logic [PORTS-1:0] tx_en,
  // Status.
  output logic jam_active,
  output logic [3:0] rx_port,
  output logic rx_overflow
);

  // The port vectors are nine bits wide throughout.
  if (PORTS != 9 || FIFO_DEPTH < 2) begin : g_chk
    $error("mrc_core: PORTS must be 9 and FIFO_DEPTH at least 2");
  end

  localparam logic [2:0] BIT_LAST = 3'(MRC_BIT_CYC - 1);
  localparam logic [2:0] BIT_HALF = 3'(MRC_BIT_CYC / 2);
  localparam logic [6:0] PRE_LAST = 7'(MRC_PREAMBLE_BITS - 1);
  localparam logic [6:0] JAM_LAST = 7'(MRC_JAM_BITS - 1);
  localparam logic [8:0] ALL_PORTS = 9'h1FF;

  // Whole state of the core.
  typedef struct packed {
    mrc_state_t st;          // Sequencer state.
    logic [3:0] owner;       // Port that owns the data path.
    logic [6:0] cnt;         // Preamble or jam bit counter.
    logic [2:0] div;         // Core clocks within one transmit bit.
    logic [8:0] car_s1;      // Carrier synchroniser, first stage.
    logic [8:0] car_s2;      // Carrier synchroniser, second stage.
    logic [8:0] car_s3;      // Carrier synchroniser, third stage.
    logic [8:0] car_f;       // Filtered carrier.
    logic [8:0] col_s1;      // Collision synchroniser, first stage.
    logic [8:0] col_s2;      // Collision synchroniser, second stage.
    logic [8:0] col_s3;      // Collision synchroniser, third stage.
    logic [8:0] col_f;       // Filtered collision.
    logic [2:0] rck_s;       // Selected receive clock synchroniser.
    logic rck_f;             // Filtered selected receive clock.
    logic [2:0] rdt_s;       // Selected receive data synchroniser.
    logic last_bit;          // Previous decoded bit, for the frame mark.
    logic sfd_seen;          // End of incoming preamble found.
    logic txc;               // Transmit bit clock.
    logic txd;               // Transmit bit.
    logic [8:0] txen;        // Transmit enables.
    logic jam;               // Jam in progress.
    logic ovf;               // A received bit found the buffer full.
  } mrc_core_t;

  mrc_core_t s_r;
  mrc_core_t s_nxt;

  // Buffer handshake.
  logic push;
  logic push_rdy;
  logic pop;
  logic pop_vld;
  logic pop_bit;
  logic flush;

  // Per-port filter outputs.
  logic [8:0] car_fn;
  logic [8:0] col_fn;

  // A level counts only once the second and third stages agree.
  for (genvar i = 0; i < PORTS; i++) begin : g_flt
    assign car_fn[i] = (s_r.car_s2[i] == s_r.car_s3[i]) ?
                       s_r.car_s2[i] : s_r.car_f[i];
    assign col_fn[i] = (s_r.col_s2[i] == s_r.col_s3[i]) ?
                       s_r.col_s2[i] : s_r.col_f[i];
  end

  // The buffer empties itself whenever no frame is in progress.
  assign flush = (s_r.st == MRC_IDLE) || (s_r.st == MRC_JAM);

  mrc_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .flush(flush),
    .in_valid(push),
    .in_ready(push_rdy),
    .in_data(s_r.rdt_s[2]),
    .out_valid(pop_vld),
    .out_ready(pop),
    .out_data(pop_bit)
  );

  // Main next-state logic.
  always_comb begin
    logic tick;
    logic rck_rise;
    logic found;
    logic [3:0] sel;
    logic col_any;
    logic col_own;
    logic own_car;
    logic [8:0] own_mask;
    tick = 1'b0;
    rck_rise = 1'b0;
    found = 1'b0;
    sel = MRC_AUI_PORT;
    col_any = 1'b0;
    col_own = 1'b0;
    own_car = 1'b0;
    own_mask = '0;
    s_nxt = s_r;
    push = 1'b0;
    pop = 1'b0;

    // Three-stage synchronisers on every asynchronous input.
    s_nxt.car_s1 = carrier;
    s_nxt.car_s2 = s_r.car_s1;
    s_nxt.car_s3 = s_r.car_s2;
    s_nxt.col_s1 = collision;
    s_nxt.col_s2 = s_r.col_s1;
    s_nxt.col_s3 = s_r.col_s2;
    s_nxt.car_f = car_fn;
    s_nxt.col_f = col_fn;

    // Only the owner's data and clock reach the decoder stage.
    s_nxt.rck_s = {s_r.rck_s[1:0], rx_clk[s_r.owner]};
    s_nxt.rdt_s = {s_r.rdt_s[1:0], rx_data[s_r.owner]};
    if (s_r.rck_s[1] == s_r.rck_s[2]) begin
      s_nxt.rck_f = s_r.rck_s[2];
    end
    // A filtered rising clock edge marks one decoded data bit.
    rck_rise = s_nxt.rck_f && !s_r.rck_f;

    // Transmit bit timing runs from the core clock by division.
    if (s_r.div == BIT_LAST) begin
      s_nxt.div = '0;
      tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 3'h1;
    end
    // Lowest numbered port with carrier wins, the attachment port first.
    for (int i = PORTS - 1; i >= 0; i--) begin
      if (car_fn[i]) begin
        found = 1'b1;
        sel = 4'(i);
      end
    end

    col_any = |col_fn;
    col_own = col_fn[s_r.owner];
    own_car = car_fn[s_r.owner];
    own_mask = 9'h001 << s_r.owner;

    // Decoded bits enter the buffer only after the frame mark.
    if (rck_rise && own_car &&
        (s_r.st == MRC_PRE || s_r.st == MRC_DATA)) begin
      s_nxt.last_bit = s_r.rdt_s[2];
      if (s_r.sfd_seen) begin
        push = 1'b1;
        if (!push_rdy) begin
          s_nxt.ovf = 1'b1;
        end
      end else if (s_r.rdt_s[2] && s_r.last_bit) begin
        s_nxt.sfd_seen = 1'b1;
      end
    end

    case (s_r.st)
      // Waiting for carrier; the block answers no address at all.
      MRC_IDLE: begin
        s_nxt.txen = '0;
        s_nxt.txd = 1'b0;
        s_nxt.sfd_seen = 1'b0;
        s_nxt.last_bit = 1'b0;
        s_nxt.cnt = '0;
        if (col_any) begin
          // A collision with no owner is jammed on every quiet port.
          s_nxt.st = MRC_JAM;
          s_nxt.jam = 1'b1;
          s_nxt.txen = ALL_PORTS & ~col_fn;
        end else if (found) begin
          s_nxt.owner = sel;
          s_nxt.st = MRC_PRE;
          s_nxt.div = '0;
          s_nxt.ovf = 1'b0;
          // First preamble bit leaves with the enables, so no dead bit.
          s_nxt.txd = 1'b1;
          s_nxt.cnt = 7'h01;
          s_nxt.txen = ALL_PORTS & ~(9'h001 << sel);
        end
      end
      // Regenerated preamble: alternating bits ending in two ones.
      MRC_PRE: begin
        if (col_any) begin
          s_nxt.st = MRC_JAM;
          s_nxt.cnt = '0;
        end else if (tick) begin
          s_nxt.txd = !s_r.cnt[0] || (s_r.cnt == PRE_LAST);
          if (s_r.cnt == PRE_LAST) begin
            s_nxt.st = MRC_DATA;
          end else begin
            s_nxt.cnt = s_r.cnt + 7'h01;
          end
        end
      end
      // Repeat buffered bits; ownership stays fixed until the path returns to idle.
      MRC_DATA, MRC_DRAIN: begin
        if (col_any) begin
          s_nxt.st = MRC_JAM;
          s_nxt.cnt = '0;
        end else begin
          if (tick) begin
            pop = pop_vld;
            s_nxt.txd = pop_vld ? pop_bit : 1'b0;
          end
          if (s_r.st == MRC_DATA && !own_car) begin
            s_nxt.st = MRC_DRAIN;
          end else if (s_r.st == MRC_DRAIN && tick && !pop_vld) begin
            // Path released only once the buffer has run dry.
            s_nxt.st = MRC_IDLE;
            s_nxt.txen = '0;
          end
        end
      end
      // Jam pattern until the count is done and collisions have gone.
      MRC_JAM: begin
        s_nxt.jam = 1'b1;
        if (tick) begin
          s_nxt.txd = !s_r.cnt[0];
          if (s_r.cnt != JAM_LAST) begin
            s_nxt.cnt = s_r.cnt + 7'h01;
          end else if (!col_any) begin
            s_nxt.st = MRC_IDLE;
            s_nxt.jam = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.st = MRC_IDLE;
      end
    endcase

    // Bit clock follows the final count, so a restart gives no short pulse.
    s_nxt.txc = (s_nxt.div >= BIT_HALF);

    // Collision enforcement on entering and during the jam.
    if (s_nxt.st == MRC_JAM && s_r.st != MRC_IDLE) begin
      s_nxt.jam = (s_nxt.st == MRC_JAM);
      if (col_own) begin
        // The receiving port reported it: jam all others.
        s_nxt.txen = ALL_PORTS & ~own_mask;
      end else begin
        // Seen on other ports: jam every port not colliding.
        s_nxt.txen = ALL_PORTS & ~col_fn;
      end
    end
    if (s_r.st == MRC_JAM && s_nxt.st == MRC_IDLE) begin
      s_nxt.txen = '0;
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_r <= '{st: MRC_IDLE, owner: MRC_AUI_PORT, car_f: MRC_PORTS_RST,
               col_f: MRC_PORTS_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tx_clk = s_r.txc;
  assign tx_data = s_r.txd;
  assign tx_en = s_r.txen;
  assign jam_active = s_r.jam;
  assign rx_port = s_r.owner;
  assign rx_overflow = s_r.ovf;

endmodule

// ### bench/mrc_props.sv
// Port checker for the repeater core, bound to every instance.
module mrc_props import mrc_pkg::*; #(
  parameter int PORTS = MRC_PORTS
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Line indications.
  input wire logic [PORTS-1:0] carrier,
  input wire logic [PORTS-1:0] collision,
  // Transmit side and status.
  input wire logic [PORTS-1:0] tx_en,
  input wire logic tx_data,
  input wire logic jam_active,
  input wire logic [3:0] rx_port
);
  // Core clocks the present jam has lasted; zero outside a jam.
  logic [10:0] jam_cyc_r;
  always_ff @(posedge clock) begin
    jam_cyc_r <= (jam_active && rstn) ? jam_cyc_r + 11'h1 : 11'h0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  owner_excluded_a: assert property (
    |tx_en && !jam_active |-> !tx_en[rx_port])
    else $error("owner port is enabled for transmit");
  owner_holds_a: assert property (
    (|tx_en && !jam_active) ##1 (|tx_en && !jam_active) |-> $stable(rx_port))
    else $error("owner changed during activity");
  start_prompt_a: assert property (
    $rose(|carrier) && tx_en == '0 && collision == '0 && !jam_active
    |-> ##[1:12] |tx_en)
    else $error("no transmit after carrier");
  jam_prompt_a: assert property (
    $rose(|collision) |-> ##[1:12] jam_active)
    else $error("collision not enforced");
  jam_length_a: assert property (
    $fell(jam_active) |-> jam_cyc_r >= 11'h2F8)
    else $error("jam shorter than its bit count");
  jam_drives_a: assert property (
    jam_active |-> |tx_en)
    else $error("jam with no port enabled");
  bit_steady_a: assert property (
    $changed(tx_data) && |tx_en && !jam_active
    |=> ($stable(tx_data) || jam_active || tx_en == '0)[*7])
    else $error("transmit bit shorter than a bit time");
  release_late_a: assert property (
    $fell(|tx_en) && !$past(jam_active) |-> !carrier[rx_port])
    else $error("path released while owner active");
  // Main scenarios reached.
  cover property (jam_active && tx_en[rx_port]);
  cover property ($fell(jam_active));
  cover property ($fell(|tx_en) && !jam_active);
endmodule
bind mrc_core mrc_props #(.PORTS(PORTS)) mrc_props_inst (
  .clock(clock), .rstn(rstn), .carrier(carrier), .collision(collision),
  .tx_en(tx_en), .tx_data(tx_data), .jam_active(jam_active),
  .rx_port(rx_port));

// ### bench/mrc_station.sv
// Behavioural stations and transceivers on the nine repeater ports.
module mrc_station (
  // Indications and decoded receive streams towards the core.
  output logic [8:0] carrier,
  output logic [8:0] collision,
  output logic [8:0] rx_data,
  output logic [8:0] rx_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ports inside a frame, the bit on the line and the idle pattern.
  logic [8:0] busy = '0;
  logic bit_q = 1'b0;
  logic [8:0] idle_q = 9'h0AA;
  initial carrier = '0;
  initial collision = '0;
  initial rx_clk = '0;
  // Idle lines wander, so a stale bit never passes for a valid one.
  always #160 idle_q = ~idle_q;
  assign rx_data = (idle_q & ~busy) | ({9{bit_q}} & busy);
  // Sets carrier and collision of one port.
  task automatic line(input int p, input logic car, input logic col);
    carrier[p] = car;
    collision[p] = col;
  endtask
  // Preamble 1010, two 1s, then data LSB first; clock only in frame.
  task automatic send_frame(input int p, input int npre,
    input logic [47:0] d, input int nd);
    // Stay off the core clock edge, so no synchroniser sample races.
    #7;
    carrier[p] = 1'b1;
    busy[p] = 1'b1;
    for (int i = 0; i < npre + 2 + nd; i++) begin
      bit_q = i < npre ? ~i[0] : (i < npre + 2 ? 1'b1 : d[i - npre - 2]);
      #80 rx_clk[p] = 1'b1;
      #160 rx_clk[p] = 1'b0;
      #80;
    end
    carrier[p] = 1'b0;
    busy[p] = 1'b0;
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the repeater core.
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("wrong value at %0t: got %0h expected %0h", \
      $time, got, exp); \
  end \
end
module testbench import mrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset and the core's ports.
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [8:0] carrier, collision, rx_data, rx_clk, tx_en;
  logic tx_clk, tx_data, jam_active, rx_overflow;
  logic [3:0] rx_port;
  // Counters and the transmit bits captured so far.
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int bit_cyc = 0;
  logic txq[$];
  mrc_core mrc_core_inst (.clock(clock), .rstn(rstn), .carrier(carrier),
    .collision(collision), .rx_data(rx_data), .rx_clk(rx_clk),
    .tx_clk(tx_clk), .tx_data(tx_data), .tx_en(tx_en),
    .jam_active(jam_active), .rx_port(rx_port),
    .rx_overflow(rx_overflow));
  mrc_station mrc_station_inst (.carrier(carrier), .collision(collision),
    .rx_data(rx_data), .rx_clk(rx_clk));
  always #(MRC_CLK_NS / 2) clock = ~clock;
  // Bits are sampled mid-bit, counted from the rise of the enables.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    bit_cyc <= tx_en == '0 ? 0 : bit_cyc + 1;
    if (tx_en != '0 && !jam_active && bit_cyc % MRC_BIT_CYC == 4) begin
      txq.push_back(tx_data);
      `CHK(tx_clk, 1'b1)
    end
    if (tx_en != '0 && !jam_active && bit_cyc % MRC_BIT_CYC == 0)
      `CHK(tx_clk, 1'b0)
    if (cycles == 40000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait for the enables (sel 0) or the jam flag to reach v.
  task automatic wait_for(input int sel, input logic v, input int lim);
    while ((sel == 0 ? tx_en != '0 : jam_active) !== v && lim > 0) begin
      lim--;
      @(posedge clock);
      #1;
    end
  endtask
  // Captured frame: regenerated preamble, then the data in order.
  task automatic chk_tx(input logic [47:0] d, input int nd);
    for (int i = 0; i < 64; i++)
      `CHK(txq[i], (i >= 62) | ~i[0])
    for (int j = 0; j < nd; j++)
      `CHK(txq[64 + j], d[j])
    txq.delete();
  endtask
  // One frame: enables, owner, overflow flag, drain and content.
  task automatic t_frame(input int p, input int npre, input logic [47:0] d,
    input int nd, input logic ovf);
    txq.delete();
    fork
      mrc_station_inst.send_frame(p, npre, d, nd);
      begin
        wait_for(0, 1'b1, 20);
        `CHK(tx_en, ~(9'h001 << p))
        `CHK(rx_port, 4'(p))
      end
    join
    wait_for(0, 1'b0, 800);
    `CHK(rx_overflow, ovf)
    chk_tx(d, ovf ? 32 : nd);
  endtask
  // Port 1 wakes while port 3 owns the path; it must be ignored.
  task automatic t_hold(input logic [47:0] d);
    txq.delete();
    fork
      mrc_station_inst.send_frame(3, 56, d, 16);
      begin
        wait_for(0, 1'b1, 20);
        mrc_station_inst.line(1, 1'b1, 1'b0);
        repeat (40) @(posedge clock);
        #1;
        `CHK(rx_port, 4'h3)
        `CHK(tx_en, 9'h1F7)
        mrc_station_inst.line(1, 1'b0, 1'b0);
      end
    join
    wait_for(0, 1'b0, 800);
    chk_tx(d, 16);
  endtask
  // Carrier on owner o, then a collision on port c; exp is the jam set.
  task automatic t_jam(input int o, input int c, input logic [8:0] exp);
    mrc_station_inst.line(o, 1'b1, 1'b0);
    wait_for(0, 1'b1, 20);
    mrc_station_inst.line(c, c == o, 1'b1);
    wait_for(1, 1'b1, 20);
    `CHK(tx_en, exp)
    #2000;
    mrc_station_inst.line(c, 1'b0, 1'b0);
    mrc_station_inst.line(o, 1'b0, 1'b0);
    wait_for(1, 1'b0, 1200);
    `CHK(jam_active, 1'b0)
    `CHK(tx_en, 9'h000)
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    t_frame(0, 56, 48'h0000_00C3_5A96, 24, 1'b0);
    t_frame(4, 8, 48'hB3C5_A1F0_6E97, 48, 1'b1);
    t_frame(8, 58, 48'h0000_00F0_1E2D, 24, 1'b0);
    t_hold(48'h0000_0000_9C3A);
    t_jam(2, 5, 9'h1DF);
    t_jam(2, 2, 9'h1FB);
    summarize();
  end
endmodule
